/* dv/flash_security_config_fuses_tb.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end

module flash_security_config_fuses_tb;
  import flash_security_pkg::*;
  // Arbitrary identity values
  localparam logic [7:0] ID_V [4] = '{8'h91, 8'h92, 8'h93, 8'h94};
  logic        clk_sys, nrst, external_access_pin;
  logic [7:0]  hsb_fuse_in;
  logic        par_req, sw_req, sw_api;
  logic [3:0]  par_cmd, sw_cmd;
  logic [2:0]  par_addr, sw_addr;
  logic [7:0]  par_wdata, sw_wdata;
  logic        config_valid_ff, fast_cycle_mode_ff, osc_b_sel_ff, expanded_ram_en_ff;
  logic        external_xdata_select_ff, code_table_read_block_ff, ext_exec_disable_ff;
  logic        ea_effective_ff, par_ack_ff, par_refused_ff, sw_ack_ff, sw_refused_ff;
  logic        chip_erase_ff, hsb_prog_ff;
  logic [15:0] boot_addr_ff, loader_addr_ff;
  logic [2:0]  lock_level_ff;
  logic [1:0]  ssb_level_ff;
  logic [7:0]  boot_status_ff, par_rdata_ff, sw_rdata_ff, hsb_prog_data_ff;
  int          n_checks, n_mismatch, cyc;

  flash_security_config_fuses #(.MFR_CODE(ID_V[0]), .DEV_ID1(ID_V[1]), .DEV_ID2(ID_V[2]),
    .DEV_ID3(ID_V[3])) dut_u (.clk_sys, .nrst, .hsb_fuse_in, .external_access_pin,
    .par_req, .par_cmd, .par_addr, .par_wdata, .sw_req, .sw_api, .sw_cmd, .sw_addr,
    .sw_wdata, .config_valid_ff, .fast_cycle_mode_ff, .boot_addr_ff, .osc_b_sel_ff,
    .expanded_ram_en_ff, .external_xdata_select_ff, .lock_level_ff, .ssb_level_ff,
    .code_table_read_block_ff, .ext_exec_disable_ff, .ea_effective_ff, .loader_addr_ff,
    .boot_status_ff, .par_ack_ff, .par_refused_ff, .par_rdata_ff, .sw_ack_ff,
    .sw_refused_ff, .sw_rdata_ff, .chip_erase_ff, .hsb_prog_ff, .hsb_prog_data_ff);

  fuse_prog_host host_u (.clk_sys, .par_req, .par_cmd, .par_addr, .par_wdata, .sw_req,
    .sw_api, .sw_cmd, .sw_addr, .sw_wdata, .par_ack_ff, .par_refused_ff, .par_rdata_ff,
    .sw_ack_ff, .sw_refused_ff, .sw_rdata_ff);

  // Free-running clock and hang guard
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      results();
    end
  end

  function automatic logic [2:0] exp_lvl(input logic [7:0] f);
    if (!f[2]) return 3'h4;
    if (!f[1]) return 3'h3;
    return f[0] ? 3'h1 : 3'h2;
  endfunction

  task automatic results;
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Six-cycle reset, then bounded wait for the decoded configuration
  task automatic do_reset(input logic [7:0] f);
    int i;
    @(negedge clk_sys);
    nrst = 1'b0;
    hsb_fuse_in = f;
    repeat (6) @(negedge clk_sys);
    nrst = 1'b1;
    i = 0;
    while (config_valid_ff !== 1'b1 && i < 20) begin
      @(negedge clk_sys);
      i++;
    end
    `CHK(config_valid_ff, 1'b1)
  endtask

  // Shared request with ack, refusal and optional read data comparison
  task automatic req(input logic sw, input logic api, input cmd_e c, input logic [2:0] a,
                     input logic [7:0] d, input logic rf_e, input logic ck,
                     input logic [7:0] rd_e);
    logic ack, rf;
    logic [7:0] rd;
    host_u.xfer(sw, api, c, a, d, ack, rf, rd);
    `CHK(ack, 1'b1)
    `CHK(rf, rf_e)
    if (ck) `CHK(rd, rd_e)
  endtask

  // Fuse decode and parallel refusals across every lock level
  task automatic sc_levels;
    logic [7:0] tbl [6] = '{8'hFF, 8'hFE, 8'h5D, 8'hFC, 8'hAB, 8'h00};
    logic [7:0] f;
    logic [2:0] lv;
    foreach (tbl[k]) begin
      f = tbl[k];
      lv = exp_lvl(f);
      external_access_pin = 1'b1;
      do_reset(f);
      `CHK(fast_cycle_mode_ff, ~f[7])
      `CHK(boot_addr_ff, f[6] ? 16'h0000 : 16'hF800)
      `CHK(osc_b_sel_ff, ~f[5])
      `CHK(expanded_ram_en_ff, f[3])
      `CHK(external_xdata_select_ff, ~f[3])
      `CHK(lock_level_ff, lv)
      `CHK(code_table_read_block_ff, lv >= 3'h2)
      `CHK(ext_exec_disable_ff, lv == 3'h4)
      `CHK(loader_addr_ff, 16'hFC00)
      req(0, 0, CMD_READ_ID, 3'h0, 8'h00, 0, 1, ID_V[0]);
      req(0, 0, CMD_PROG_CODE, 3'h0, 8'h5A, lv >= 3'h2, 1, 8'h00);
      req(0, 0, CMD_EE_WRITE, 3'h0, 8'h5A, lv >= 3'h2, 1, 8'h00);
      req(0, 0, CMD_VERIFY_CODE, 3'h0, 8'h00, lv >= 3'h3, 0, 8'h00);
      req(0, 0, CMD_EE_READ, 3'h0, 8'h00, lv >= 3'h3, 0, 8'h00);
      req(1, 0, CMD_PROG_CODE, 3'h0, 8'h5A, 0, 1, 8'h00);
      req(1, 0, CMD_READ_HSB, 3'h0, 8'h00, 1, 1, 8'h00);
      req(1, 1, CMD_READ_HSB, 3'h0, 8'h00, 1, 1, 8'h00);
      // Pin and fuse changes after the sample must not disturb the decode, except the pin at level 1
      external_access_pin = 1'b0;
      hsb_fuse_in = ~f;
      repeat (8) @(negedge clk_sys);
      `CHK(ea_effective_ff, lv >= 3'h2)
      `CHK(lock_level_ff, lv)
      `CHK(fast_cycle_mode_ff, ~f[7])
    end
  endtask

  // Extra page defaults through parallel and API paths, vector rewrite
  task automatic sc_extra_page;
    logic [7:0] exp_v [8] = '{8'hFC, 8'hAB, 8'hFF, 8'hFF, ID_V[0], ID_V[1], ID_V[2], ID_V[3]};
    do_reset(8'hFF);
    for (int i = 0; i < 8; i++) begin
      req(0, 0, CMD_XAF_READ, 3'(i), 8'h00, 0, 1, exp_v[i]);
      req(1, 1, CMD_XAF_READ, 3'(i), 8'h00, 0, 1, exp_v[i]);
    end
    req(0, 0, CMD_XAF_WRITE, XAF_MFR, 8'h00, 1, 1, 8'h00);
    req(0, 0, CMD_XAF_WRITE, XAF_SBV, 8'h70, 0, 1, 8'h00);
    repeat (2) @(negedge clk_sys);
    `CHK(loader_addr_ff, 16'h7000)
  endtask

  // Serial lock levels from the software byte, parallel port unaffected
  task automatic sc_serial_lock;
    do_reset(8'hFF);
    req(1, 0, CMD_XAF_WRITE, XAF_SSB, 8'hFE, 0, 1, 8'h00);
    repeat (2) @(negedge clk_sys);
    `CHK(ssb_level_ff, 2'h2)
    req(1, 0, CMD_PROG_CODE, 3'h0, 8'h5A, 1, 1, 8'h00);
    req(1, 0, CMD_VERIFY_CODE, 3'h0, 8'h00, 0, 0, 8'h00);
    req(1, 1, CMD_PROG_CODE, 3'h0, 8'h5A, 0, 1, 8'h00);
    req(1, 0, CMD_XAF_WRITE, XAF_SSB, 8'hFD, 0, 1, 8'h00);
    repeat (2) @(negedge clk_sys);
    `CHK(ssb_level_ff, 2'h3)
    req(1, 0, CMD_VERIFY_CODE, 3'h0, 8'h00, 1, 1, 8'h00);
    req(0, 0, CMD_XAF_READ, XAF_SSB, 8'h00, 0, 1, 8'hFC);
    req(0, 0, CMD_PROG_CODE, 3'h0, 8'h5A, 0, 1, 8'h00);
  endtask

  // Chip erase at top level, then host clears the boot status byte
  task automatic sc_erase;
    do_reset(8'hAB);
    req(1, 0, CMD_XAF_WRITE, XAF_SSB, 8'hFE, 0, 1, 8'h00);
    req(0, 0, CMD_PROG_CODE, 3'h0, 8'h5A, 1, 1, 8'h00);
    req(0, 0, CMD_CHIP_ERASE, 3'h0, 8'h00, 0, 1, 8'h00);
    `CHK(chip_erase_ff, 1'b1)
    @(negedge clk_sys);
    `CHK(lock_level_ff, 3'h1)
    `CHK(ssb_level_ff, 2'h1)
    req(0, 0, CMD_PROG_CODE, 3'h0, 8'h5A, 0, 1, 8'h00);
    // Verify first, then program a lock level into the fuse byte
    req(0, 0, CMD_VERIFY_CODE, 3'h0, 8'h00, 0, 1, 8'h00);
    req(0, 0, CMD_WRITE_HSB, 3'h0, 8'hFE, 0, 1, 8'h00);
    `CHK(hsb_prog_ff, 1'b1)
    `CHK(hsb_prog_data_ff, 8'hFE)
    req(1, 0, CMD_XAF_WRITE, XAF_BSB, 8'h00, 0, 1, 8'h00);
    repeat (2) @(negedge clk_sys);
    `CHK(boot_status_ff, 8'h00)
  endtask

  // Main sequence
  initial begin
    n_checks = 0;
    n_mismatch = 0;
    cyc = 0;
    nrst = 1'b0;
    hsb_fuse_in = 8'hFF;
    external_access_pin = 1'b1;
    sc_levels();
    sc_extra_page();
    sc_serial_lock();
    sc_erase();
    results();
  end
endmodule

/* dv/fuse_prog_host.sv */
`timescale 1ns/1ps
// Programmer and serial host on the far side of both request ports
module fuse_prog_host
  import flash_security_pkg::*;
(
  input  wire logic       clk_sys,
  output logic            par_req,
  output logic [3:0]      par_cmd,
  output logic [2:0]      par_addr,
  output logic [7:0]      par_wdata,
  output logic            sw_req,
  output logic            sw_api,
  output logic [3:0]      sw_cmd,
  output logic [2:0]      sw_addr,
  output logic [7:0]      sw_wdata,
  input  wire logic       par_ack_ff,
  input  wire logic       par_refused_ff,
  input  wire logic [7:0] par_rdata_ff,
  input  wire logic       sw_ack_ff,
  input  wire logic       sw_refused_ff,
  input  wire logic [7:0] sw_rdata_ff
);
  // Idle at time zero
  initial begin
    {par_req, par_cmd, par_addr, par_wdata} = '0;
    {sw_req, sw_api, sw_cmd, sw_addr, sw_wdata} = '0;
  end

  // One request after a falling edge; answer taken one cycle later
  task automatic xfer(input logic sw, input logic api, input cmd_e cmd, input logic [2:0] a,
                      input logic [7:0] d, output logic ack, output logic rf,
                      output logic [7:0] rd);
    logic [7:0] wd;
    wd = d;
    // Upper bits of the software byte are never cleared by the host
    if (cmd == CMD_XAF_WRITE && a == XAF_SSB) wd = d | 8'hFC;
    @(negedge clk_sys);
    if (sw) begin
      {sw_req, sw_api, sw_cmd, sw_addr, sw_wdata} <= {1'b1, api, cmd, a, wd};
    end else begin
      {par_req, par_cmd, par_addr, par_wdata} <= {1'b1, cmd, a, wd};
    end
    @(negedge clk_sys);
    ack = sw ? sw_ack_ff : par_ack_ff;
    rf  = sw ? sw_refused_ff : par_refused_ff;
    rd  = sw ? sw_rdata_ff : par_rdata_ff;
    // Released command, address and data lines flip so a stale value never looks valid
    if (sw) begin
      {sw_req, sw_cmd, sw_addr, sw_wdata} <= {1'b0, ~sw_cmd, ~sw_addr, ~sw_wdata};
    end else begin
      {par_req, par_cmd, par_addr, par_wdata} <= {1'b0, ~par_cmd, ~par_addr, ~par_wdata};
    end
  endtask
endmodule

/* include/flash_security_pkg.sv */
package flash_security_pkg;

  // Extra page word indices
  localparam int          XAF_DEPTH = 8;
  localparam logic [2:0]  XAF_SBV   = 3'h0;
  localparam logic [2:0]  XAF_HSB   = 3'h1;
  localparam logic [2:0]  XAF_BSB   = 3'h2;
  localparam logic [2:0]  XAF_SSB   = 3'h3;
  localparam logic [2:0]  XAF_MFR   = 3'h4;
  localparam logic [2:0]  XAF_ID1   = 3'h5;
  localparam logic [2:0]  XAF_ID2   = 3'h6;
  localparam logic [2:0]  XAF_ID3   = 3'h7;

  // Fuse bit positions in the hardware security byte
  localparam int HSB_FAST_BIT = 7;
  localparam int HSB_BOOT_BIT = 6;
  localparam int HSB_OSC_BIT  = 5;
  localparam int HSB_EXPANDED_RAM_INHIBIT_BIT = 3;
  localparam int LOCK_B2_BIT  = 2;
  localparam int LOCK_B1_BIT  = 1;
  localparam int LOCK_B0_BIT  = 0;

  // Reset and erase values
  localparam logic [7:0]  SBV_DEFAULT      = 8'hFC;
  localparam logic [7:0]  BSB_DEFAULT      = 8'hFF;
  localparam logic [7:0]  SSB_DEFAULT      = 8'hFF;
  localparam logic [7:0]  HSB_COPY_DEFAULT = 8'hAB;
  localparam logic [7:0]  HSB_ERASED       = 8'hFF;
  localparam logic [7:0]  LOADER_LOW       = 8'h00;
  localparam logic [7:0]  DATA_ZERO        = 8'h00;
  localparam logic [15:0] BOOT_APP_ADDR    = 16'h0000;
  localparam logic [15:0] BOOT_ROM_ADDR    = 16'hF800;

  // Cycles the pin synchroniser needs before the reset-time sample
  localparam logic [1:0]  SETTLE_CYCLES    = 2'h3;
  localparam logic [1:0]  SETTLE_ZERO      = 2'h0;
  localparam logic [1:0]  SETTLE_ONE       = 2'h1;

  typedef enum logic [2:0] {
    LVL_ONE   = 3'h1,
    LVL_TWO   = 3'h2,
    LVL_THREE = 3'h3,
    LVL_FOUR  = 3'h4
  } lock_level_e;

  typedef enum logic [1:0] {
    SSB_ONE   = 2'h1,
    SSB_TWO   = 2'h2,
    SSB_THREE = 2'h3
  } ssb_level_e;

  typedef enum logic [3:0] {
    CMD_READ_ID     = 4'h0,
    CMD_READ_HSB    = 4'h1,
    CMD_WRITE_HSB   = 4'h2,
    CMD_CHIP_ERASE  = 4'h3,
    CMD_PROG_CODE   = 4'h4,
    CMD_VERIFY_CODE = 4'h5,
    CMD_EE_WRITE    = 4'h6,
    CMD_EE_READ     = 4'h7,
    CMD_XAF_READ    = 4'h8,
    CMD_XAF_WRITE   = 4'h9
  } cmd_e;

  typedef enum logic [1:0] {
    PH_SETTLE = 2'b00,
    PH_SAMPLE = 2'b01,
    PH_RUN    = 2'b10
  } phase_e;

endpackage

/* rtl/flash_security_config_fuses.sv */
`timescale 1ns/1ps

// Summary of operation
// - Fuse bit 7 zero selects six-clock fast mode, one selects standard mode.
// - Boot jump fuse one boots at 0000h, zero boots loader at F800h.
// - Programmed clock fuse enables oscillator B, otherwise oscillator A.
// - Programmed RAM inhibit fuse disables expanded RAM; programmer only changes it.
// - All parallel lock bits unprogrammed means no protection.
// - Level 2 blocks external table reads of internal code; access pin latched.
// - Level 2 and up refuse parallel code and data programming; internal allowed.
// - Level 3 also refuses parallel verify and parallel data reads.
// - Level 4 also disables external execution; delivered default.
// - Parallel locks gate only the parallel port; serial uses software byte.
// - Parallel chip erase clears Flash and returns fuse byte to inactive.
// - Part identification is readable in parallel mode at every level.
// - Fuse byte reachable only through the parallel port.
// - Extra page outside program space, reached by parallel, serial and API.
// - Extra page defaults: vector FCh, status FFh, software byte FFh.
// - Extra page holds a fuse byte copy, default 101x 1011b.
// - Extra page holds maker code and three identification bytes.
// - Software lock bit 0 alone rejects serial Flash programming.
// - Software lock bit 1 also rejects serial verification.
// - External data select initialised from RAM fuse, on-chip by default.
// - Customer loader entered at boot vector high byte and low 00h.
module flash_security_config_fuses
  import flash_security_pkg::*;
#(
  parameter logic [7:0] MFR_CODE = 8'h1E,  // Arbitrary identity value
  parameter logic [7:0] DEV_ID1  = 8'h2D,  // Arbitrary identity value
  parameter logic [7:0] DEV_ID2  = 8'h3C,  // Arbitrary identity value
  parameter logic [7:0] DEV_ID3  = 8'h4B   // Arbitrary identity value
)(
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic [7:0]  hsb_fuse_in,
  input  wire logic        external_access_pin,
  input  wire logic        par_req,
  input  wire logic [3:0]  par_cmd,
  input  wire logic [2:0]  par_addr,
  input  wire logic [7:0]  par_wdata,
  input  wire logic        sw_req,
  input  wire logic        sw_api,
  input  wire logic [3:0]  sw_cmd,
  input  wire logic [2:0]  sw_addr,
  input  wire logic [7:0]  sw_wdata,
  output logic             config_valid_ff,
  output logic             fast_cycle_mode_ff,
  output logic [15:0]      boot_addr_ff,
  output logic             osc_b_sel_ff,
  output logic             expanded_ram_en_ff,
  output logic             external_xdata_select_ff,
  output logic [2:0]       lock_level_ff,
  output logic [1:0]       ssb_level_ff,
  output logic             code_table_read_block_ff,
  output logic             ext_exec_disable_ff,
  output logic             ea_effective_ff,
  output logic [15:0]      loader_addr_ff,
  output logic [7:0]       boot_status_ff,
  output logic             par_ack_ff,
  output logic             par_refused_ff,
  output logic [7:0]       par_rdata_ff,
  output logic             sw_ack_ff,
  output logic             sw_refused_ff,
  output logic [7:0]       sw_rdata_ff,
  output logic             chip_erase_ff,
  output logic             hsb_prog_ff,
  output logic [7:0]       hsb_prog_data_ff
);

  phase_e      phase_ff;
  logic [1:0]  settle_ff;
  logic [7:0]  hardware_security_byte_ff;
  logic [7:0]  xaf_mem [0:XAF_DEPTH-1];
  logic        ea_meta_ff;
  logic        ea_s2_ff;
  logic        ea_s3_ff;
  logic        ea_level_ff;
  logic        ea_latched_ff;
  lock_level_e par_lvl;
  ssb_level_e  sw_lvl;
  cmd_e        par_c;
  cmd_e        sw_c;
  logic        running;
  logic        par_ok;
  logic [7:0]  par_data;
  logic        sw_ok;
  logic [7:0]  sw_data;
  logic        par_go;
  logic        sw_go;
  logic [2:0]  par_id_idx;
  logic [2:0]  sw_id_idx;
  logic [7:0]  software_security_byte;

  assign running                = (phase_ff == PH_RUN);
  assign par_c                  = cmd_e'(par_cmd);
  assign sw_c                   = cmd_e'(sw_cmd);
  assign par_go                 = par_req && running && par_ok;
  assign sw_go                  = sw_req && running && sw_ok;
  assign par_id_idx             = XAF_MFR | {1'b0, par_addr[1:0]};
  assign sw_id_idx              = XAF_MFR | {1'b0, sw_addr[1:0]};
  assign software_security_byte = xaf_mem[XAF_SSB];

  // Reset phase: let the pin synchroniser fill, sample once, then run
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      phase_ff  <= PH_SETTLE;
      settle_ff <= SETTLE_ZERO;
    end else begin
      unique case (phase_ff)
        PH_SETTLE: begin
          settle_ff <= settle_ff + SETTLE_ONE;
          if (settle_ff == SETTLE_CYCLES) begin
            phase_ff <= PH_SAMPLE;
          end
        end
        PH_SAMPLE: phase_ff <= PH_RUN;
        PH_RUN:    phase_ff <= PH_RUN;
        default:   phase_ff <= PH_SETTLE;
      endcase
    end
  end

  // Three-stage pin synchroniser; level moves only when stages 2 and 3 agree
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      ea_meta_ff  <= 1'b1;
      ea_s2_ff    <= 1'b1;
      ea_s3_ff    <= 1'b1;
      ea_level_ff <= 1'b1;
    end else begin
      ea_meta_ff <= external_access_pin;
      ea_s2_ff   <= ea_meta_ff;
      ea_s3_ff   <= ea_s2_ff;
      if (ea_s2_ff == ea_s3_ff) begin
        ea_level_ff <= ea_s3_ff;
      end
    end
  end

  // Fuse byte held from the reset sample; reset value is the most protective
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      hardware_security_byte_ff <= HSB_COPY_DEFAULT;
      ea_latched_ff             <= 1'b1;
    end else if (phase_ff == PH_SAMPLE) begin
      hardware_security_byte_ff <= hsb_fuse_in;
      ea_latched_ff             <= ea_level_ff;
    end else if (par_go && par_c == CMD_CHIP_ERASE) begin
      hardware_security_byte_ff <= HSB_ERASED;
    end
  end

  // Parallel lock level, highest programmed bit first
  always_comb begin
    if (!hardware_security_byte_ff[LOCK_B2_BIT]) begin
      par_lvl = LVL_FOUR;
    end else if (!hardware_security_byte_ff[LOCK_B1_BIT]) begin
      par_lvl = LVL_THREE;
    end else if (!hardware_security_byte_ff[LOCK_B0_BIT]) begin
      par_lvl = LVL_TWO;
    end else begin
      par_lvl = LVL_ONE;
    end
  end

  // Serial lock level from the software security byte
  always_comb begin
    if (!software_security_byte[LOCK_B1_BIT]) begin
      sw_lvl = SSB_THREE;
    end else if (!software_security_byte[LOCK_B0_BIT]) begin
      sw_lvl = SSB_TWO;
    end else begin
      sw_lvl = SSB_ONE;
    end
  end

  // Parallel command filter; parallel locks gate only this port
  always_comb begin
    par_ok   = 1'b1;
    par_data = DATA_ZERO;
    unique case (par_c)
      CMD_READ_ID:     par_data = xaf_mem[par_id_idx];
      CMD_READ_HSB:    par_data = hardware_security_byte_ff;
      CMD_WRITE_HSB:   par_ok   = 1'b1;
      CMD_CHIP_ERASE:  par_ok   = 1'b1;
      CMD_PROG_CODE:   par_ok   = (par_lvl < LVL_TWO);
      CMD_EE_WRITE:    par_ok   = (par_lvl < LVL_TWO);
      CMD_VERIFY_CODE: par_ok   = (par_lvl < LVL_THREE);
      CMD_EE_READ:     par_ok   = (par_lvl < LVL_THREE);
      CMD_XAF_READ:    par_data = xaf_mem[par_addr];
      CMD_XAF_WRITE:   par_ok   = (par_addr < XAF_MFR) && (par_addr != XAF_HSB);
      default:         par_ok   = 1'b0;
    endcase
  end

  // Serial and API filter; the fuse byte is never reachable here
  always_comb begin
    sw_ok   = 1'b1;
    sw_data = DATA_ZERO;
    unique case (sw_c)
      CMD_READ_ID:     sw_data = xaf_mem[sw_id_idx];
      CMD_READ_HSB:    sw_ok   = 1'b0;
      CMD_WRITE_HSB:   sw_ok   = 1'b0;
      CMD_CHIP_ERASE:  sw_ok   = 1'b0;
      CMD_PROG_CODE:   sw_ok   = sw_api || (sw_lvl == SSB_ONE);
      CMD_EE_WRITE:    sw_ok   = sw_api || (sw_lvl == SSB_ONE);
      CMD_VERIFY_CODE: sw_ok   = sw_api || (sw_lvl != SSB_THREE);
      CMD_EE_READ:     sw_ok   = sw_api || (sw_lvl != SSB_THREE);
      CMD_XAF_READ: begin
        sw_ok   = sw_api || (sw_lvl != SSB_THREE);
        sw_data = xaf_mem[sw_addr];
      end
      CMD_XAF_WRITE: begin
        if (sw_addr == XAF_SSB) begin
          sw_ok = 1'b1;
        end else begin
          sw_ok = (sw_addr < XAF_MFR) && (sw_addr != XAF_HSB)
                  && (sw_api || (sw_lvl == SSB_ONE));
        end
      end
      default:         sw_ok   = 1'b0;
    endcase
  end

  // Extra page; software byte writes only move toward more protection, chip erase restores FFh
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      xaf_mem[XAF_SBV] <= SBV_DEFAULT;
      xaf_mem[XAF_HSB] <= HSB_COPY_DEFAULT;
      xaf_mem[XAF_BSB] <= BSB_DEFAULT;
      xaf_mem[XAF_SSB] <= SSB_DEFAULT;
      xaf_mem[XAF_MFR] <= MFR_CODE;
      xaf_mem[XAF_ID1] <= DEV_ID1;
      xaf_mem[XAF_ID2] <= DEV_ID2;
      xaf_mem[XAF_ID3] <= DEV_ID3;
    end else if (par_go && par_c == CMD_CHIP_ERASE) begin
      xaf_mem[XAF_SSB] <= SSB_DEFAULT;
      xaf_mem[XAF_HSB] <= HSB_ERASED;
    end else if (par_go && par_c == CMD_WRITE_HSB) begin
      xaf_mem[XAF_HSB] <= hardware_security_byte_ff & par_wdata;
    end else if (par_go && par_c == CMD_XAF_WRITE) begin
      if (par_addr == XAF_SSB) begin
        xaf_mem[XAF_SSB] <= software_security_byte & par_wdata;
      end else begin
        xaf_mem[par_addr] <= par_wdata;
      end
    end else if (sw_go && sw_c == CMD_XAF_WRITE) begin
      if (sw_addr == XAF_SSB) begin
        xaf_mem[XAF_SSB] <= software_security_byte & sw_wdata;
      end else begin
        xaf_mem[sw_addr] <= sw_wdata;
      end
    end
  end

  // Parallel answers, one cycle after the request
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      par_ack_ff       <= 1'b0;
      par_refused_ff   <= 1'b0;
      par_rdata_ff     <= DATA_ZERO;
      chip_erase_ff    <= 1'b0;
      hsb_prog_ff      <= 1'b0;
      hsb_prog_data_ff <= HSB_ERASED;
    end else begin
      par_ack_ff     <= par_req;
      par_refused_ff <= par_req && !par_go;
      par_rdata_ff   <= par_go ? par_data : DATA_ZERO;
      chip_erase_ff  <= par_go && (par_c == CMD_CHIP_ERASE);
      hsb_prog_ff    <= par_go && (par_c == CMD_WRITE_HSB);
      // Fuses only program toward zero; erase is the way back
      if (par_go && par_c == CMD_WRITE_HSB) begin
        hsb_prog_data_ff <= hardware_security_byte_ff & par_wdata;
      end
    end
  end

  // Serial and API answers, one cycle after the request
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      sw_ack_ff     <= 1'b0;
      sw_refused_ff <= 1'b0;
      sw_rdata_ff   <= DATA_ZERO;
    end else begin
      sw_ack_ff     <= sw_req;
      sw_refused_ff <= sw_req && !sw_go;
      sw_rdata_ff   <= sw_go ? sw_data : DATA_ZERO;
    end
  end

  // Decoded configuration; updated only once the sample is in
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      config_valid_ff          <= 1'b0;
      fast_cycle_mode_ff       <= 1'b0;
      boot_addr_ff             <= BOOT_ROM_ADDR;
      osc_b_sel_ff             <= 1'b0;
      expanded_ram_en_ff       <= 1'b1;
      lock_level_ff            <= LVL_FOUR;
      ssb_level_ff             <= SSB_ONE;
      code_table_read_block_ff <= 1'b1;
      ext_exec_disable_ff      <= 1'b1;
      ea_effective_ff          <= 1'b1;
      loader_addr_ff           <= {SBV_DEFAULT, LOADER_LOW};
      boot_status_ff           <= BSB_DEFAULT;
    end else if (running) begin
      config_valid_ff          <= 1'b1;
      fast_cycle_mode_ff       <= !hardware_security_byte_ff[HSB_FAST_BIT];
      boot_addr_ff             <= hardware_security_byte_ff[HSB_BOOT_BIT]
                                  ? BOOT_APP_ADDR : BOOT_ROM_ADDR;
      osc_b_sel_ff             <= !hardware_security_byte_ff[HSB_OSC_BIT];
      expanded_ram_en_ff       <= hardware_security_byte_ff[HSB_EXPANDED_RAM_INHIBIT_BIT];
      lock_level_ff            <= par_lvl;
      ssb_level_ff             <= sw_lvl;
      code_table_read_block_ff <= (par_lvl >= LVL_TWO);
      ext_exec_disable_ff      <= (par_lvl == LVL_FOUR);
      // Latched pin once protected, so a later pin swap cannot expose code
      ea_effective_ff          <= (par_lvl >= LVL_TWO) ? ea_latched_ff
                                                       : ea_level_ff;
      loader_addr_ff           <= {xaf_mem[XAF_SBV], LOADER_LOW};
      boot_status_ff           <= xaf_mem[XAF_BSB];
    end
  end

  // Data select is only preset at power-up; later software owns it
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      external_xdata_select_ff <= 1'b0;
    end else if (phase_ff == PH_SAMPLE) begin
      external_xdata_select_ff <= !hsb_fuse_in[HSB_EXPANDED_RAM_INHIBIT_BIT];
    end
  end

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  chk_fast_mode_decode: assert property (
    running |=> fast_cycle_mode_ff == !$past(hardware_security_byte_ff[HSB_FAST_BIT]))
    else $error("fast mode does not follow fuse bit");

  chk_boot_addr: assert property (
    running |=> boot_addr_ff == ($past(hardware_security_byte_ff[HSB_BOOT_BIT])
                                 ? BOOT_APP_ADDR : BOOT_ROM_ADDR))
    else $error("boot address wrong for jump fuse");

  chk_osc_ram_sel: assert property (
    running |=> osc_b_sel_ff != $past(hardware_security_byte_ff[HSB_OSC_BIT])
                && expanded_ram_en_ff == $past(hardware_security_byte_ff[HSB_EXPANDED_RAM_INHIBIT_BIT]))
    else $error("oscillator or RAM enable wrong");

  chk_par_prog_lock: assert property (
    par_req && running && lock_level_ff >= LVL_TWO && par_lvl >= LVL_TWO
    && (par_c == CMD_PROG_CODE || par_c == CMD_EE_WRITE) |=> par_ack_ff && par_refused_ff)
    else $error("parallel programming accepted while locked");

  chk_par_verify_lock: assert property (
    par_req && running && par_lvl >= LVL_THREE && par_c == CMD_VERIFY_CODE
    |=> par_refused_ff && par_rdata_ff == DATA_ZERO)
    else $error("parallel verify accepted at level three");

  chk_id_always: assert property (
    par_req && running && par_c == CMD_READ_ID |=> par_ack_ff && !par_refused_ff)
    else $error("identification read refused");

  chk_hsb_hidden: assert property (
    sw_req && (sw_c == CMD_READ_HSB || sw_c == CMD_WRITE_HSB) |=> sw_refused_ff)
    else $error("fuse byte reached from serial side");

  chk_isp_prog_lock: assert property (
    sw_req && !sw_api && sw_lvl != SSB_ONE && sw_c == CMD_PROG_CODE |=> sw_refused_ff)
    else $error("serial programming accepted while locked");

  chk_isp_verify_lock: assert property (
    sw_req && !sw_api && sw_lvl == SSB_THREE && sw_c == CMD_VERIFY_CODE
    |=> sw_refused_ff)
    else $error("serial verify accepted at level three");

  chk_erase_release: assert property (
    par_req && running && par_c == CMD_CHIP_ERASE
    |=> chip_erase_ff ##1 lock_level_ff == LVL_ONE)
    else $error("chip erase did not release locks");

  chk_lock_priority: assert property (
    running && !hardware_security_byte_ff[LOCK_B2_BIT] |=> lock_level_ff == LVL_FOUR)
    else $error("top lock bit did not win");

  chk_sample_held: assert property (
    running && !(par_req && par_c == CMD_CHIP_ERASE)
    |=> $stable(hardware_security_byte_ff))
    else $error("fuse sample changed without erase");

  chk_config_ready: assert property (
    $rose(nrst) |-> ##[5:7] config_valid_ff)
    else $error("configuration not valid in time");

  cov_erase: cover property (par_req && running && par_c == CMD_CHIP_ERASE);
  cov_isp_refused: cover property (sw_refused_ff && !sw_api);
  cov_level_four: cover property (config_valid_ff && lock_level_ff == LVL_FOUR);

endmodule
